// ### design/qasc_top.sv
// Output control of a four-channel pipelined converter: sampling pipeline,
// format and power-down handling, six-times serial clock, frame and serializer.
// Assumes the conversion clock is a pin sampled by mclk, well below mclk/12,
// and software reaches the few control and status words over AXI4-Lite.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps

module qasc_top #(
  parameter logic [15:0] REF_SETTLE = 16'(qasc_pkg::REF_SETTLE_CYCLES)
) (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire qasc_pkg::qasc_pins_t    pinsIn,
  input  wire qasc_pkg::qasc_axi_req_t axiReq,
  output qasc_pkg::qasc_axi_rsp_t      axiRsp,
  output qasc_pkg::qasc_lvds_t         lvdsOut,
  output logic                         refEnable
);
  import qasc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       convPrev;
    logic [15:0]                periodCnt;
    logic [15:0]                period;
    logic                       locked;
    logic                       midDone;
    logic                       loadNext;
    logic [4:0]                 halfStep;
    logic [3:0]                 bitIdx;
    logic [15:0]                acc;
    logic                       serActive;
    logic [NCH-1:0][WORD_W-1:0] word;
    logic [15:0]                settleCnt;
    logic                       refReady;
    logic                       refEn;
    logic                       testPattern;
    logic                       awGot;
    logic                       wGot;
    logic [ADDR_W-1:0]          awAddr;
    logic [31:0]                wData;
    logic [3:0]                 wStrb;
    qasc_axi_rsp_t              rsp;
    qasc_lvds_t                 lvds;
  } qasc_top_t;

  qasc_top_t         s;
  qasc_top_t         n;
  qasc_pins_t        pins;
  logic              rise;
  logic [NCH-1:0]    pdVec;
  logic [15:0]       accSum;
  logic [WORD_W-1:0] w;
  logic [3:0]        bits;
  logic [31:0]       status;
  logic              ramWe;
  logic [RAM_AW-1:0] ramWaddr;
  logic [RAM_AW-1:0] ramRaddr;
  logic [RAM_W-1:0]  ramRdata;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pins swing both ways of a differential pair
  function automatic qasc_lvds_t drive(input logic [3:0] d, input logic c, input logic f);
    qasc_lvds_t o;
    o.dataOutPos           = d;
    o.dataOutNeg           = ~d;
    o.serial_clock_out_pos = c;
    o.serial_clock_out_neg = ~c;
    o.word_frame_out_pos   = f;
    o.word_frame_out_neg   = ~f;
    return o;
  endfunction

  // offset binary is two's complement with the sign bit flipped
  function automatic logic [WORD_W-1:0] encode(input logic [WORD_W-1:0] x,
                                               input logic bin);
    return bin ? {~x[WORD_W-1], x[WORD_W-2:0]} : x;
  endfunction

  // registers sit on aligned words; low address bits are ignored
  function automatic logic regAt(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  // periods within one mclk of each other count as stable
  function automatic logic near(input logic [15:0] a, input logic [15:0] b);
    return (a == b) || (16'(a + 16'h0001) == b) || (a == 16'(b + 16'h0001));
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser and sample memory
  // ----------------------------------------------------------------
  // core words only change away from the sampling edge and are captured on
  // it, so a plain bundle synchroniser is safe for them
  qasc_sync #(
    .W ($bits(qasc_pins_t))
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      (pinsIn),
    .q      (pins)
  );

  qasc_ram u_ram (
    .mclk   (mclk),
    .resetn (resetn),
    .we     (ramWe),
    .waddr  (ramWaddr),
    .wdata  (pins.coreSample),
    .raddr  (ramRaddr),
    .rdata  (ramRdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n          = s;
    n.loadNext = 1'b0;
    rise       = pins.convClk & ~s.convPrev;
    pdVec      = {pins.chan3_powerdown, pins.chan2_powerdown,
                  pins.chan1_powerdown, pins.chan0_powerdown}
                 | {NCH{pins.global_powerdown}};
    accSum     = 16'(s.acc + BITS_PER_WORD);
    w          = '0;
    bits       = '0;
    ramWe      = 1'b0;
    ramWaddr   = s.halfStep[4:1];
    ramRaddr   = 4'(s.halfStep[4:1] - RD_BACK);
    n.convPrev = pins.convClk;

    // rising conversion edge: capture all four channels together
    if (rise) begin
      n.period    = 16'(s.periodCnt + 16'h0001);
      n.periodCnt = '0;
      n.locked    = near(n.period, s.period) && (n.period >= MIN_PERIOD);
      n.midDone   = 1'b0;
      ramWe       = 1'b1;
      n.halfStep  = {4'(s.halfStep[4:1] + 4'h1), 1'b0};
    end else if (s.periodCnt != 16'hffff) begin
      n.periodCnt = 16'(s.periodCnt + 16'h0001);
    end else begin
      // conversion clock has stopped
      n.locked = 1'b0;
    end

    // second half step placed at half the measured period, not at the
    // falling pin edge, so the input duty cycle does not matter
    if (!rise && !s.midDone && s.locked && (s.periodCnt == {1'b0, s.period[15:1]})) begin
      n.midDone  = 1'b1;
      n.halfStep = s.halfStep | 5'h01;
      n.loadNext = 1'b1;
    end

    // serializer: one slot per period/12 by a fractional accumulator
    if (s.loadNext) begin
      for (int i = 0; i < NCH; i++) begin
        w = s.testPattern ? TEST_PATTERN
                          : encode(ramRdata[i*WORD_W +: WORD_W], pins.formatBinary);
        if (pdVec[i]) begin
          w = '0;
        end
        n.word[i] = w;
        bits[i]   = w[0];
      end
      n.serActive = s.locked & ~pins.global_powerdown;
      n.bitIdx    = '0;
      n.acc       = '0;
      // frame and clock rise with the first bit of the new word
      n.lvds      = n.serActive ? drive(bits, 1'b1, 1'b1) : drive(4'h0, 1'b0, 1'b0);
    end else if (s.serActive && (s.bitIdx != LAST_BIT)) begin
      if (accSum >= s.period) begin
        n.acc    = 16'(accSum - s.period);
        n.bitIdx = 4'(s.bitIdx + 4'h1);
        for (int i = 0; i < NCH; i++) begin
          n.word[i] = {1'b0, s.word[i][WORD_W-1:1]};
          bits[i]   = n.word[i][0];
        end
        // one clock toggle per bit: six clock periods per word
        n.lvds = drive(bits, ~s.lvds.serial_clock_out_pos,
                       n.bitIdx < HALF_WORD);
      end else begin
        n.acc = accSum;
      end
    end

    // global power-down stops every channel at once
    if (pins.global_powerdown) begin
      n.serActive = 1'b0;
      n.lvds      = drive(4'h0, 1'b0, 1'b0);
    end

    // reference enable and settling count
    if (pins.global_powerdown) begin
      n.refEn     = 1'b0;
      n.refReady  = 1'b0;
      n.settleCnt = '0;
    end else begin
      n.refEn = 1'b1;
      if (s.settleCnt >= 16'(REF_SETTLE - 16'h0001)) begin
        n.refReady = 1'b1;
      end else begin
        n.settleCnt = 16'(s.settleCnt + 16'h0001);
      end
    end

    // ----------------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------------
    if (s.rsp.awready && axiReq.awvalid) begin
      n.awGot  = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (s.rsp.wready && axiReq.wvalid) begin
      n.wGot  = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
    end
    if (s.rsp.bvalid && axiReq.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.awGot && s.wGot && !s.rsp.bvalid) begin
      n.awGot      = 1'b0;
      n.wGot       = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = RESP_SLVERR;
      if (regAt(s.awAddr, ADDR_CTRL)) begin
        n.rsp.bresp = RESP_OKAY;
        if (s.wStrb[0]) begin
          n.testPattern = s.wData[CTRL_TEST];
        end
      end
    end
    n.rsp.awready = ~n.awGot & ~n.rsp.bvalid;
    n.rsp.wready  = ~n.wGot & ~n.rsp.bvalid;

    // ----------------------------------------------------------------
    // axi4-lite read
    // ----------------------------------------------------------------
    status                                   = '0;
    status[ST_LOCKED]                        = s.locked;
    status[ST_REF_READY]                     = s.refReady;
    status[ST_GPD]                           = pins.global_powerdown;
    status[ST_REF_ON]                        = s.refEn;
    status[ST_PD_LSB +: NCH]                 = pdVec;
    status[ST_REF_MODE]                      = pins.ref_mode_select;
    status[ST_STRAP_LSB +: 4]                = {pins.pll_range_bit2, pins.pll_range_bit1,
                                                pins.pll_range_bit0, pins.pll_factory_strap};
    if (s.rsp.rvalid && axiReq.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (s.rsp.arready && axiReq.arvalid) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = RESP_OKAY;
      if (regAt(axiReq.araddr, ADDR_CTRL)) begin
        n.rsp.rdata = {31'h0, s.testPattern};
      end else if (regAt(axiReq.araddr, ADDR_STATUS)) begin
        n.rsp.rdata = status;
      end else if (regAt(axiReq.araddr, ADDR_PERIOD)) begin
        n.rsp.rdata = {16'h0, s.period};
      end else begin
        n.rsp.rdata = '0;
        n.rsp.rresp = RESP_SLVERR;
      end
    end
    n.rsp.arready = ~n.rsp.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s             <= '0;
      s.testPattern <= CTRL_RESET;
    end else begin
      s <= n;
    end
  end

  assign axiRsp    = s.rsp;
  assign lvdsOut   = s.lvds;
  assign refEnable = s.refEn;
endmodule

// ### design/qasc_pkg.sv
// Shared constants and carrier types for the quad converter output control block.
// Assumes a single 200 MHz system clock; all pins arrive asynchronously to it.

package qasc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ           = 200;
  localparam int          REF_SETTLE_US     = 132;
  localparam int          REF_SETTLE_CYCLES = REF_SETTLE_US * CLK_MHZ;
  localparam int          LAT_HALF_STEPS    = 13;
  localparam logic [3:0]  RD_BACK           = 4'((LAT_HALF_STEPS + 1) / 2);
  localparam logic [15:0] MIN_PERIOD        = 16'h000c;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int          NCH           = 4;
  localparam int          WORD_W        = 12;
  localparam logic [15:0] BITS_PER_WORD = 16'h000c;
  localparam logic [3:0]  LAST_BIT      = 4'hb;
  localparam logic [3:0]  HALF_WORD     = 4'h6;
  localparam logic [11:0] TEST_PATTERN  = 12'h0bd;
  localparam int          RAM_AW        = 4;
  localparam int          RAM_W         = NCH * WORD_W;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD  = 8'h08;
  localparam int         CTRL_TEST    = 0;
  localparam logic       CTRL_RESET   = 1'h0;
  localparam int         ST_LOCKED    = 0;
  localparam int         ST_REF_READY = 1;
  localparam int         ST_GPD       = 2;
  localparam int         ST_REF_ON    = 3;
  localparam int         ST_PD_LSB    = 4;
  localparam int         ST_REF_MODE  = 8;
  localparam int         ST_STRAP_LSB = 12;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       convClk;
    logic                       chan3_powerdown;
    logic                       chan2_powerdown;
    logic                       chan1_powerdown;
    logic                       chan0_powerdown;
    logic                       global_powerdown;
    logic                       formatBinary;
    logic                       ref_mode_select;
    logic                       pll_range_bit2;
    logic                       pll_range_bit1;
    logic                       pll_range_bit0;
    logic                       pll_factory_strap;
    logic [NCH-1:0][WORD_W-1:0] coreSample;
  } qasc_pins_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } qasc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } qasc_axi_rsp_t;

  typedef struct packed {
    logic [NCH-1:0] dataOutPos;
    logic [NCH-1:0] dataOutNeg;
    logic           serial_clock_out_pos;
    logic           serial_clock_out_neg;
    logic           word_frame_out_pos;
    logic           word_frame_out_neg;
  } qasc_lvds_t;

endpackage

// ### design/qasc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is a level held far longer than one mclk period.
`timescale 1ns/100ps

module qasc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qasc_sync_t;

  qasc_sync_t s;
  qasc_sync_t n;

  // first stage feeds the second stage only
  always_comb begin
    n    = s;
    n.s1 = d;
    n.s2 = s.s1;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.s2;
endmodule

// ### design/qasc_ram.sv
// Sample delay memory: one write and one read port, read data registered.
// Assumes write and read addresses differ whenever both are used.
`timescale 1ns/100ps

module qasc_ram
  import qasc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              we,
  input  wire logic [RAM_AW-1:0] waddr,
  input  wire logic [RAM_W-1:0]  wdata,
  input  wire logic [RAM_AW-1:0] raddr,
  output logic [RAM_W-1:0]       rdata
);
  typedef struct packed {
    logic [(1<<RAM_AW)-1:0][RAM_W-1:0] mem;
    logic [RAM_W-1:0]                  rd;
  } qasc_ram_t;

  qasc_ram_t s;
  qasc_ram_t n;

  always_comb begin
    n    = s;
    n.rd = s.mem[raddr];
    if (we) begin
      n.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rd;
endmodule

// ### test/qasc_sva.sv
// Checker for qasc_top, bound from the bench top file.
// Assumes one mclk domain with synchronous active-low reset.
`timescale 1ns/100ps

module qasc_sva #(
  parameter logic [15:0] REF_SETTLE = 16'h0032
) (
  input wire logic                    mclk,
  input wire logic                    resetn,
  input wire qasc_pkg::qasc_pins_t    pinsIn,
  input wire qasc_pkg::qasc_axi_req_t axiReq,
  input wire qasc_pkg::qasc_axi_rsp_t axiRsp,
  input wire qasc_pkg::qasc_lvds_t    lvdsOut,
  input wire logic                    refEnable
);
  import qasc_pkg::*;
  logic       sClk;
  logic       frm;
  logic       clkQ;
  logic       seen;
  logic [4:0] edges;
  logic [3:0] idle;
  assign sClk = lvdsOut.serial_clock_out_pos;
  assign frm  = lvdsOut.word_frame_out_pos;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // serial clock toggles per word; a quiet link forgets the last word
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clkQ  <= 1'b0;
      idle  <= 4'h0;
      seen  <= 1'b0;
      edges <= 5'h0;
    end else begin
      clkQ <= sClk;
      idle <= (sClk != clkQ) ? 4'h0 : (idle != 4'hf) ? idle + 4'h1 : idle;
      if (idle > 4'h8) begin
        seen  <= 1'b0;
        edges <= 5'h0;
      end else if ($rose(frm)) begin
        seen  <= 1'b1;
        edges <= 5'h1;
      end else if (sClk != clkQ) begin
        edges <= edges + 5'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pair_apart: assert property ((lvdsOut.dataOutPos & lvdsOut.dataOutNeg) == 4'h0)
    else $error("both halves of a data pair high");
  a_pair_inverse: assert property ((sClk || frm) |->
    lvdsOut.serial_clock_out_neg == !sClk && lvdsOut.word_frame_out_neg == !frm
    && (lvdsOut.dataOutPos ^ lvdsOut.dataOutNeg) == 4'hf) else $error("pair halves not inverse");
  a_frame_edge: assert property ($rose(frm) |-> $rose(sClk))
    else $error("frame rose without serial clock rise");
  a_frame_high: assert property (disable iff (!resetn || pinsIn.global_powerdown)
    $rose(frm) |-> frm[*8]) else $error("frame high too short");
  a_frame_low: assert property ($fell(frm) |-> !frm[*8])
    else $error("frame low too short");
  a_word_edges: assert property ($rose(frm) && seen |-> edges == 5'hc)
    else $error("serial clock edges per word not twelve");
  a_gpd_quiet: assert property (pinsIn.global_powerdown[*8] |-> !sClk && !frm)
    else $error("link active in global power-down");
  a_ref_off: assert property (pinsIn.global_powerdown[*8] |-> !refEnable)
    else $error("reference on in global power-down");
  a_ref_on: assert property (!pinsIn.global_powerdown[*8] |-> refEnable)
    else $error("reference off outside power-down");
  a_wr_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##2 axiRsp.bvalid) else $error("write answer late");
  a_rd_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  c_word: cover property ($rose(frm) && seen);
  c_gpd: cover property (pinsIn.global_powerdown[*8]);
  c_read: cover property (axiRsp.rvalid && axiReq.rready);
endmodule

// ### test/qasc_rx_model.sv
// Receiving deserializer: rebuilds the four channel words from the link.
// Assumes link outputs are registered on mclk, so one sample per slot is enough.
`timescale 1ns/100ps

module qasc_rx_model (
  input  wire logic                 mclk,
  input  wire qasc_pkg::qasc_lvds_t lvdsIn,
  input  wire logic [31:0]          cyc,
  output logic [3:0][11:0]          word,
  output logic [31:0]               startCyc
);
  import qasc_pkg::*;
  logic [3:0][11:0] shift = '0;
  logic [3:0]       idx = 4'hf;
  logic [31:0]      begunAt = 32'h0;
  logic             clkQ = 1'b0;
  logic             frmQ = 1'b0;
  initial word = '0;
  initial startCyc = 32'h0;

  // ----------------------------------------------------------------
  // every clock toggle opens a bit slot; frame rise restarts the word
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    clkQ <= lvdsIn.serial_clock_out_pos;
    frmQ <= lvdsIn.word_frame_out_pos;
    if (lvdsIn.serial_clock_out_pos != clkQ) begin
      if (lvdsIn.word_frame_out_pos && !frmQ) begin
        idx = 4'h0;
        begunAt = cyc;
      end
      if (idx < 4'hc) begin
        for (int c = 0; c < NCH; c++) shift[c][idx] = lvdsIn.dataOutPos[c];
      end
      if (idx == 4'hb) begin
        word <= shift;
        startCyc <= begunAt;
      end
      if (idx != 4'hf) idx = idx + 4'h1;
    end
  end
endmodule

// ### test/tb.sv
// Self-checking bench for qasc_top: registers, serial words, power-down.
// Assumes 200 MHz mclk; the conversion clock is made here, unrelated in phase.
`timescale 1ns/100ps

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

module tb;
  import qasc_pkg::*;
  localparam logic [15:0] SETTLE = 16'h0032;
  logic             mclk = 1'b0;
  logic             resetn = 1'b0;
  qasc_pins_t       pins;
  qasc_axi_req_t    req;
  qasc_axi_rsp_t    rsp;
  qasc_lvds_t       lvds;
  logic             refEnable;
  logic [31:0]      cyc = 32'h0;
  logic [31:0]      rd;
  logic [31:0]      tRise;
  logic [1:0]       resp;
  logic [3:0][11:0] rxWord;
  logic [31:0]      rxStart;
  int               miscompares = 0;
  int               checked = 0;
  int               highNs = 80;

  qasc_top #(.REF_SETTLE(SETTLE)) u_dut (.mclk(mclk), .resetn(resetn), .pinsIn(pins),
    .axiReq(req), .axiRsp(rsp), .lvdsOut(lvds), .refEnable(refEnable));
  qasc_rx_model u_rx (.mclk(mclk), .lvdsIn(lvds), .cyc(cyc), .word(rxWord),
    .startCyc(rxStart));

  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 32'h1;
  initial begin
    #1.3;
    forever begin
      pins.convClk = 1'b1;
      #(highNs);
      pins.convClk = 1'b0;
      #(160 - highNs);
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up(input int n);
    if (n >= 400) begin
      miscompares++;
      $display("BAD wait exp done got timeout");
      test_done();
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 400);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    give_up(n);
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 400);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    give_up(n);
  endtask
  // words before lock and reference settling are not trusted
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      axi_read(ADDR_STATUS);
      n++;
    end while (rd[1:0] !== 2'h3 && n < 400);
    give_up(n);
  endtask
  task automatic settle_words(input int n);
    repeat (n) @(posedge pins.convClk);
    @(posedge mclk);
  endtask
  // change core words away from the sampling edge
  task automatic put_sample(input logic [3:0][11:0] s);
    @(negedge pins.convClk);
    @(posedge mclk);
    pins.coreSample <= s;
    @(posedge pins.convClk);
    tRise = cyc;
  endtask
  function automatic logic [11:0] exp_word(input logic [11:0] s, input logic fmt,
                                           input logic pd);
    return pd ? 12'h000 : (fmt ? {~s[11], s[10:0]} : s);
  endfunction
  task automatic check_words(input logic [3:0][11:0] s, input logic [3:0] pd);
    for (int c = 0; c < NCH; c++) begin
      `CHK("word", exp_word(s[c], pins.formatBinary, pd[c]), rxWord[c])
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0][11:0] smp;
    int               n;
    void'($urandom(32'hbef2));
    pins = '0; // factory strap stays at ground
    req = '0;
    {pins.ref_mode_select, pins.pll_range_bit2, pins.pll_range_bit1, pins.pll_range_bit0}
      = 4'($urandom);
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    axi_read(ADDR_CTRL);
    `CHK("ctrl reset", 32'h0, rd)
    axi_write(ADDR_CTRL, 32'h1);
    `CHK("ctrl write", RESP_OKAY, resp)
    axi_read(ADDR_CTRL);
    `CHK("ctrl", 32'h1, rd)
    axi_write(ADDR_CTRL, 32'h0);
    axi_write(ADDR_STATUS, 32'hffff);
    `CHK("status write", RESP_SLVERR, resp)
    axi_read(8'h0c);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {resp, rd})
    axi_read(ADDR_STATUS);
    `CHK("straps", {pins.pll_range_bit2, pins.pll_range_bit1, pins.pll_range_bit0, 1'b0},
      rd[15:12])
    `CHK("ref mode", pins.ref_mode_select, rd[8])
    wait_ready();
    axi_read(ADDR_PERIOD);
    `CHK("period", 32'h20, rd)
    axi_write(ADDR_CTRL, 32'h1);
    settle_words(3);
    for (int c = 0; c < NCH; c++) `CHK("pattern", TEST_PATTERN, rxWord[c])
    axi_write(ADDR_CTRL, 32'h0);
    $display("register test done");
    for (int f = 0; f < 2; f++) begin
      pins.formatBinary <= f[0];
      highNs = f ? 32 : 128; // 80 then 20 percent duty
      for (int k = 0; k < 5; k++) begin
        smp = 48'({$urandom, $urandom});
        if (k == 0) smp = {12'h800, 12'h7ff, 12'h000, 12'hfff};
        put_sample(smp);
        n = 0;
        while (rxWord[0] !== exp_word(smp[0], f[0], 1'b0) && n < 400) begin
          @(posedge mclk);
          n++;
        end
        give_up(n);
        `CHK("latency", 1'b1, (rxStart - tRise) inside {[208:218]})
        settle_words(2);
        check_words(smp, 4'h0);
      end
      $display("format test done");
    end
    for (int c = 0; c < NCH; c++) begin
      @(posedge mclk);
      {pins.chan3_powerdown, pins.chan2_powerdown, pins.chan1_powerdown,
       pins.chan0_powerdown} <= 4'(1 << c);
      settle_words(9);
      check_words(smp, 4'(1 << c));
      axi_read(ADDR_STATUS);
      `CHK("pd status", 4'(1 << c), rd[7:4])
    end
    $display("channel power-down test done");
    @(posedge mclk);
    pins.chan3_powerdown <= 1'b0;
    pins.global_powerdown <= 1'b1;
    settle_words(2);
    `CHK("ref enable off", 1'b0, refEnable)
    `CHK("link idle", 1'b0, lvds.serial_clock_out_pos)
    axi_read(ADDR_STATUS);
    `CHK("gpd status", 5'h1f, {rd[7:4], rd[2]})
    pins.global_powerdown <= 1'b0;
    tRise = cyc;
    n = 0;
    do begin
      axi_read(ADDR_STATUS);
      n++;
    end while (rd[1] !== 1'b1 && n < 400);
    give_up(n);
    `CHK("settle time", 1'b1, (cyc - tRise) inside {[52:70]})
    wait_ready();
    smp = 48'({$urandom, $urandom});
    put_sample(smp);
    settle_words(9);
    check_words(smp, 4'h0);
    $display("global power-down test done");
    test_done();
  end
endmodule

bind qasc_top qasc_sva #(.REF_SETTLE(REF_SETTLE)) u_sva (.mclk(mclk), .resetn(resetn),
  .pinsIn(pinsIn), .axiReq(axiReq), .axiRsp(axiRsp), .lvdsOut(lvdsOut),
  .refEnable(refEnable));
